// ### l2a_arbiter.sv
// l2 command-slot arbiter among global coherence, cpu, dma path and user coherence
// assumes requestors on the same clock; a register slave on avalon-mm sets priorities
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Behaviour
// - the competing cpu or dma request with the numerically lower priority wins the slot
// - per-requestor lost counter; reaching its threshold forces that requestor to win unless global coherence or an earlier starved requestor competes
// - global coherence always first, user coherence last unless starved; only cpu and dma compare
// - slave dma priority comes with its command; local dma from the local dma priority register
// - cpu priority comes from the software-written cpu priority register
// - priorities are three-bit, zero highest and seven lowest
// - reset priorities: local dma zero, cpu one, peripheral defaults as listed
// - equal cpu and dma priority alternates the grant between the two
// - final slave dma command with nothing pending competes at priority seven
// - a demoted pending command inherits the priority of a newly started transfer
module l2a_arbiter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [l2a_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic glb_coh_req,
  input wire logic cpu_req,
  input wire logic slave_dma_req,
  input wire logic [l2a_pkg::PW-1:0] slave_dma_pri,
  input wire logic slave_dma_last,
  input wire logic slave_dma_xfer_start,
  input wire logic [l2a_pkg::PW-1:0] slave_dma_xfer_pri,
  input wire logic local_dma_req,
  input wire logic usr_coh_req,
  output logic [l2a_pkg::NRQ-1:0] grant,
  output logic grant_local_dma
);
  import l2a_pkg::*;
  typedef struct packed {
    logic [NRQ-1:0] grant;
    logic gnt_local;
    logic alt;
    logic inh_v;
    logic [PW-1:0] inh_pri;
  } l2a_arb_st_t;
  l2a_arb_st_t st;
  l2a_arb_st_t next_st;

  l2a_cfg_if cfg ();

  logic [NRQ-1:0] req;
  logic [NRQ-1:0] elig;
  logic [NRQ-1:0] win;
  logic [NRQ-1:0] lost;
  logic [NRQ-1:0] starved;
  logic [THR_W-1:0] thr_vec [NRQ];
  logic sd_elig;
  logic ld_elig;
  logic use_sd;
  logic both_cd;
  logic equal_cd;
  logic [PW-1:0] sd_eff;
  logic [PW-1:0] dma_pri;

  l2a_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg(cfg.regs)
  );

  // global coherence never starves, so its threshold is parked at the top
  always_comb begin
    thr_vec[RQ_GLB] = {THR_W{1'b1}};
    thr_vec[RQ_CPU] = cfg.thr_cpu;
    thr_vec[RQ_DMA] = cfg.thr_dma;
    thr_vec[RQ_USR] = cfg.thr_usr;
  end

  for (genvar i = 0; i < NRQ; i++) begin : g_ctr
    l2a_lost_ctr #(
      .W(THR_W)
    ) u_ctr (
      .clk(clk),
      .sys_rst(sys_rst),
      .lost(lost[i]),
      .won(win[i]),
      .thr(thr_vec[i]),
      .starved(starved[i])
    );
  end

  always_comb begin
    next_st = st;
    req = '0;
    req[RQ_GLB] = glb_coh_req;
    req[RQ_CPU] = cpu_req;
    req[RQ_DMA] = slave_dma_req | local_dma_req;
    req[RQ_USR] = usr_coh_req;
    // the cycle after a grant the old command still shows, so it is skipped
    elig = req & ~st.grant;
    sd_elig = slave_dma_req & ~(st.grant[RQ_DMA] & ~st.gnt_local);
    ld_elig = local_dma_req & ~(st.grant[RQ_DMA] & st.gnt_local);
    elig[RQ_DMA] = sd_elig | ld_elig;
    // final command of a transfer drops to the lowest level unless it inherited
    if (slave_dma_last) begin
      sd_eff = st.inh_v ? st.inh_pri : PRI_LOWEST;
    end else begin
      sd_eff = slave_dma_pri;
    end
    use_sd = sd_elig & (~ld_elig | (sd_eff <= cfg.ldma_pri));
    dma_pri = use_sd ? sd_eff : cfg.ldma_pri;
    both_cd = elig[RQ_CPU] & elig[RQ_DMA];
    equal_cd = both_cd & (cfg.cpu_pri == dma_pri);
    win = '0;
    if (elig[RQ_GLB]) begin
      win[RQ_GLB] = 1'b1;
    end else if (elig[RQ_DMA] && starved[RQ_DMA]) begin
      win[RQ_DMA] = 1'b1;
    end else if (elig[RQ_CPU] && starved[RQ_CPU]) begin
      win[RQ_CPU] = 1'b1;
    end else if (elig[RQ_USR] && starved[RQ_USR]) begin
      win[RQ_USR] = 1'b1;
    end else if (equal_cd) begin
      win[st.alt ? RQ_DMA : RQ_CPU] = 1'b1;
    end else if (both_cd) begin
      win[(cfg.cpu_pri < dma_pri) ? RQ_CPU : RQ_DMA] = 1'b1;
    end else if (elig[RQ_CPU]) begin
      win[RQ_CPU] = 1'b1;
    end else if (elig[RQ_DMA]) begin
      win[RQ_DMA] = 1'b1;
    end else if (elig[RQ_USR]) begin
      win[RQ_USR] = 1'b1;
    end
    lost = elig & ~win & {NRQ{|win}};
    next_st.grant = win;
    next_st.gnt_local = win[RQ_DMA] & ~use_sd;
    // alt set means the dma side is owed the next equal-priority slot
    if (win[RQ_CPU]) begin
      next_st.alt = 1'b1;
    end else if (win[RQ_DMA]) begin
      next_st.alt = 1'b0;
    end
    if (win[RQ_DMA] && use_sd) begin
      next_st.inh_v = 1'b0;
    end else if (slave_dma_xfer_start && slave_dma_req && slave_dma_last) begin
      next_st.inh_v = 1'b1;
      next_st.inh_pri = slave_dma_xfer_pri;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign grant = st.grant;
  assign grant_local_dma = st.gnt_local;
  assign cfg.st_grant = st.grant;
  assign cfg.st_sd_eff = sd_eff;
  assign cfg.st_demoted = slave_dma_req & slave_dma_last & ~st.inh_v;
  assign cfg.st_alt = st.alt;

  // software is expected to keep cpu off priority seven; demoted dma would then tie forever
  logic no_starve;
  assign no_starve = ~|(starved & elig);

  property p_glb_first;
    @(posedge clk) disable iff (sys_rst) elig[RQ_GLB] |=> grant == 4'h1;
  endproperty
  a_glb_first: assert property (p_glb_first) else $error("global coherence not first");

  property p_cpu_wins_pri;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && no_starve && both_cd && cfg.cpu_pri < dma_pri |=> grant[RQ_CPU];
  endproperty
  a_cpu_wins_pri: assert property (p_cpu_wins_pri) else $error("cpu lost on priority");

  property p_dma_wins_pri;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && no_starve && both_cd && dma_pri < cfg.cpu_pri |=> grant[RQ_DMA];
  endproperty
  a_dma_wins_pri: assert property (p_dma_wins_pri) else $error("dma lost on priority");

  property p_starved_dma;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && elig[RQ_DMA] && starved[RQ_DMA] |=> grant[RQ_DMA];
  endproperty
  a_starved_dma: assert property (p_starved_dma) else $error("starved dma not granted");

  property p_alternate;
    @(posedge clk) disable iff (sys_rst)
      grant[RQ_CPU] ##1 (!grant[RQ_DMA] && !elig[RQ_GLB] && no_starve && equal_cd)
      |=> grant[RQ_DMA];
  endproperty
  a_alternate: assert property (p_alternate) else $error("equal priority did not alternate");

  property p_demote;
    @(posedge clk) disable iff (sys_rst)
      sd_elig && slave_dma_last && !st.inh_v && !ld_elig && elig[RQ_CPU]
      && cfg.cpu_pri < PRI_LOWEST && !elig[RQ_GLB] && no_starve |=> grant[RQ_CPU];
  endproperty
  a_demote: assert property (p_demote) else $error("last dma command not demoted");

  property p_inherit;
    @(posedge clk) disable iff (sys_rst)
      slave_dma_xfer_start && slave_dma_req && slave_dma_last && !(win[RQ_DMA] && use_sd)
      |=> st.inh_v && st.inh_pri == $past(slave_dma_xfer_pri);
  endproperty
  a_inherit: assert property (p_inherit) else $error("priority not inherited");

  property p_user_last;
    @(posedge clk) disable iff (sys_rst)
      grant[RQ_USR] |-> !$past(elig[RQ_GLB]) && ($past(starved[RQ_USR])
      || !$past(elig[RQ_CPU] || elig[RQ_DMA]));
  endproperty
  a_user_last: assert property (p_user_last) else $error("user coherence jumped ahead");

  property p_onehot;
    @(posedge clk) disable iff (sys_rst) $onehot0(grant);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one grant");

  // the granted side is masked for a cycle, so the tie it owes shows one cycle later
  property p_alternate_back;
    @(posedge clk) disable iff (sys_rst)
      grant[RQ_DMA] ##1 (!grant[RQ_CPU] && !elig[RQ_GLB] && no_starve && equal_cd)
      |=> grant[RQ_CPU];
  endproperty
  a_alternate_back: assert property (p_alternate_back) else $error("tie not returned to cpu");

  property p_starved_cpu;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && !(elig[RQ_DMA] && starved[RQ_DMA]) && elig[RQ_CPU] && starved[RQ_CPU]
      |=> grant[RQ_CPU];
  endproperty
  a_starved_cpu: assert property (p_starved_cpu) else $error("starved cpu not granted");

  property p_starved_usr;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && !(elig[RQ_DMA] && starved[RQ_DMA])
      && !(elig[RQ_CPU] && starved[RQ_CPU]) && elig[RQ_USR] && starved[RQ_USR]
      |=> grant[RQ_USR];
  endproperty
  a_starved_usr: assert property (p_starved_usr) else $error("starved user not granted");

  property p_pick_local;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && no_starve && !elig[RQ_CPU] && sd_elig && ld_elig
      && sd_eff > cfg.ldma_pri |=> grant[RQ_DMA] && grant_local_dma;
  endproperty
  a_pick_local: assert property (p_pick_local) else $error("local dma lost on priority");

  property p_pick_slave;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && no_starve && !elig[RQ_CPU] && sd_elig && ld_elig
      && sd_eff <= cfg.ldma_pri |=> grant[RQ_DMA] && !grant_local_dma;
  endproperty
  a_pick_slave: assert property (p_pick_slave) else $error("slave dma lost on priority");

  property p_dma_before_user;
    @(posedge clk) disable iff (sys_rst)
      !elig[RQ_GLB] && !elig[RQ_CPU] && elig[RQ_DMA] && !(elig[RQ_USR] && starved[RQ_USR])
      |=> grant[RQ_DMA];
  endproperty
  a_dma_before_user: assert property (p_dma_before_user) else $error("user ahead of dma");

  property p_user_idle;
    @(posedge clk) disable iff (sys_rst)
      elig[RQ_USR] && !elig[RQ_GLB] && !elig[RQ_CPU] && !elig[RQ_DMA] |=> grant[RQ_USR];
  endproperty
  a_user_idle: assert property (p_user_idle) else $error("lone user not granted");

  property p_idle_no_grant;
    @(posedge clk) disable iff (sys_rst) elig == 4'h0 |=> grant == 4'h0;
  endproperty
  a_idle_no_grant: assert property (p_idle_no_grant) else $error("grant with no request");

  property p_grant_has_req;
    @(posedge clk) disable iff (sys_rst) (grant & ~$past(req)) == 4'h0;
  endproperty
  a_grant_has_req: assert property (p_grant_has_req) else $error("grant to idle requestor");

  property p_inherit_clear;
    @(posedge clk) disable iff (sys_rst)
      grant[RQ_DMA] && !grant_local_dma |-> !st.inh_v;
  endproperty
  a_inherit_clear: assert property (p_inherit_clear) else $error("inherit kept after grant");

  c_alternate: cover property (@(posedge clk) disable iff (sys_rst)
    equal_cd ##1 grant[RQ_CPU] ##1 grant[RQ_DMA]);
  c_starve: cover property (@(posedge clk) disable iff (sys_rst)
    starved[RQ_DMA] && elig[RQ_DMA] && elig[RQ_CPU] && cfg.cpu_pri < dma_pri);
  c_demote: cover property (@(posedge clk) disable iff (sys_rst)
    cfg.st_demoted && sd_elig);
  c_local: cover property (@(posedge clk) disable iff (sys_rst)
    grant[RQ_DMA] && grant_local_dma);
  c_inherit: cover property (@(posedge clk) disable iff (sys_rst)
    st.inh_v && slave_dma_req ##1 grant[RQ_DMA] && !grant_local_dma);
endmodule

// ### l2a_pkg.sv
// constants and field layout for the l2 requestor priority arbiter
// assumes one core clock; shared by the arbiter, its register slave and its counters
package l2a_pkg;
  // priority encoding: 0 highest, 7 lowest
  localparam int PW = 3;
  localparam logic [PW-1:0] PRI_HIGHEST = 3'h0;
  localparam logic [PW-1:0] PRI_LOWEST = 3'h7;
  // reset priorities of the sources behind the dma path and of the cpu
  localparam logic [PW-1:0] PRI_XFER_CTRL_RST = 3'h0;
  localparam logic [PW-1:0] PRI_PKT_LINK_RST = 3'h0;
  localparam logic [PW-1:0] PRI_EMAC_RST = 3'h1;
  localparam logic [PW-1:0] PRI_HOST_RST = 3'h2;
  localparam logic [PW-1:0] PRI_SER_BRIDGE_RST = 3'h4;
  localparam logic [PW-1:0] MASTER_DMA_PORT_PRIORITY_RST = 3'h7;
  localparam logic [PW-1:0] CPU_PRI_RST = 3'h1;
  localparam logic [PW-1:0] LDMA_PRI_RST = 3'h0;
  // starvation threshold width and reset value
  localparam int THR_W = 8;
  localparam logic [THR_W-1:0] THR_RST = 8'h10;
  // requestor indices
  localparam int NRQ = 4;
  localparam int RQ_GLB = 0;
  localparam int RQ_CPU = 1;
  localparam int RQ_DMA = 2;
  localparam int RQ_USR = 3;
  // register byte offsets
  localparam int AW = 4;
  localparam logic [AW-1:0] OFS_CPU_PRI = 4'h0;
  localparam logic [AW-1:0] OFS_LDMA = 4'h4;
  localparam logic [AW-1:0] OFS_THR = 4'h8;
  localparam logic [AW-1:0] OFS_STAT = 4'hc;
  // field positions
  localparam int CPU_PRI_LSB = 0;
  localparam int LDMA_PRI_LSB = 0;
  localparam int THR_CPU_LSB = 0;
  localparam int THR_DMA_LSB = 8;
  localparam int THR_USR_LSB = 16;
  localparam int STAT_GNT_LSB = 0;
  localparam int STAT_EFF_LSB = 4;
  localparam int STAT_DEM_BIT = 7;
  localparam int STAT_ALT_BIT = 8;
endpackage

// ### l2a_cfg_if.sv
// configuration and status carried between the register slave and the arbiter core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface l2a_cfg_if;
  import l2a_pkg::*;
  logic [PW-1:0] cpu_pri;
  logic [PW-1:0] ldma_pri;
  logic [THR_W-1:0] thr_cpu;
  logic [THR_W-1:0] thr_dma;
  logic [THR_W-1:0] thr_usr;
  logic [NRQ-1:0] st_grant;
  logic [PW-1:0] st_sd_eff;
  logic st_demoted;
  logic st_alt;
  modport regs (output cpu_pri, ldma_pri, thr_cpu, thr_dma, thr_usr,
                input st_grant, st_sd_eff, st_demoted, st_alt);
  modport core (input cpu_pri, ldma_pri, thr_cpu, thr_dma, thr_usr,
                output st_grant, st_sd_eff, st_demoted, st_alt);
endinterface

// ### l2a_lost_ctr.sv
// lost-arbitration counter of one requestor, saturating, with threshold compare
// assumes lost and won are never high together
`timescale 1ns/1ps
module l2a_lost_ctr #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lost,
  input wire logic won,
  input wire logic [W-1:0] thr,
  output logic starved
);
  import l2a_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
  } l2a_ctr_st_t;
  l2a_ctr_st_t st;
  l2a_ctr_st_t next_st;

  if (W < 1 || W > 16) begin : g_chk
    $error("l2a_lost_ctr: W out of range");
  end

  always_comb begin
    next_st = st;
    if (won) begin
      next_st.cnt = '0;
    end else if (lost && st.cnt != {W{1'b1}}) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // threshold of zero keeps the requestor starved, so it wins unless global coherence or an earlier starved requestor competes
  assign starved = (st.cnt >= thr);

  property p_clear_on_win;
    @(posedge clk) disable iff (sys_rst) won |=> st.cnt == '0;
  endproperty
  a_clear_on_win: assert property (p_clear_on_win) else $error("counter not cleared on grant");

  property p_count_loss;
    @(posedge clk) disable iff (sys_rst)
      lost && st.cnt != {W{1'b1}} |=> st.cnt == $past(st.cnt) + 1'b1;
  endproperty
  a_count_loss: assert property (p_count_loss) else $error("lost cycle not counted");
endmodule

// ### l2a_regs.sv
// avalon-mm register slave of the arbiter: priorities, thresholds and status
// assumes a master that holds its request until waitrequest is seen low
`timescale 1ns/1ps
module l2a_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [l2a_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  l2a_cfg_if.regs cfg
);
  import l2a_pkg::*;
  typedef struct packed {
    logic wrq;
    logic [31:0] rdata;
    logic [PW-1:0] cpu_pri;
    logic [PW-1:0] ldma_pri;
    logic [THR_W-1:0] thr_cpu;
    logic [THR_W-1:0] thr_dma;
    logic [THR_W-1:0] thr_usr;
  } l2a_reg_st_t;
  l2a_reg_st_t st;
  l2a_reg_st_t next_st;
  logic req;
  logic [31:0] rd_mux;

  always_comb begin
    next_st = st;
    req = avs_read | avs_write;
    rd_mux = 32'h0;
    unique case (avs_address)
      OFS_CPU_PRI: rd_mux[CPU_PRI_LSB +: PW] = st.cpu_pri;
      OFS_LDMA: rd_mux[LDMA_PRI_LSB +: PW] = st.ldma_pri;
      OFS_THR: rd_mux = {8'h0, st.thr_usr, st.thr_dma, st.thr_cpu};
      OFS_STAT: begin
        rd_mux[STAT_GNT_LSB +: NRQ] = cfg.st_grant;
        rd_mux[STAT_EFF_LSB +: PW] = cfg.st_sd_eff;
        rd_mux[STAT_DEM_BIT] = cfg.st_demoted;
        rd_mux[STAT_ALT_BIT] = cfg.st_alt;
      end
      default: rd_mux = 32'h0;
    endcase
    // one wait cycle per access keeps read data registered
    next_st.wrq = ~(req & st.wrq);
    if (avs_read && st.wrq) begin
      next_st.rdata = rd_mux;
    end
    if (avs_write && !st.wrq) begin
      unique case (avs_address)
        OFS_CPU_PRI: next_st.cpu_pri = avs_writedata[CPU_PRI_LSB +: PW];
        OFS_LDMA: next_st.ldma_pri = avs_writedata[LDMA_PRI_LSB +: PW];
        OFS_THR: begin
          next_st.thr_cpu = avs_writedata[THR_CPU_LSB +: THR_W];
          next_st.thr_dma = avs_writedata[THR_DMA_LSB +: THR_W];
          next_st.thr_usr = avs_writedata[THR_USR_LSB +: THR_W];
        end
        default: next_st.wrq = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{wrq: 1'b1, rdata: 32'h0, cpu_pri: CPU_PRI_RST, ldma_pri: LDMA_PRI_RST,
              thr_cpu: THR_RST, thr_dma: THR_RST, thr_usr: THR_RST};
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wrq;
  assign cfg.cpu_pri = st.cpu_pri;
  assign cfg.ldma_pri = st.ldma_pri;
  assign cfg.thr_cpu = st.thr_cpu;
  assign cfg.thr_dma = st.thr_dma;
  assign cfg.thr_usr = st.thr_usr;

  property p_cpu_pri_write;
    @(posedge clk) disable iff (sys_rst)
      avs_write && !st.wrq && avs_address == OFS_CPU_PRI
      |=> cfg.cpu_pri == $past(avs_writedata[CPU_PRI_LSB +: PW]);
  endproperty
  a_cpu_pri_write: assert property (p_cpu_pri_write) else $error("cpu priority write lost");

  property p_reset_defaults;
    @(posedge clk) $past(sys_rst) && !sys_rst
      |-> cfg.cpu_pri == CPU_PRI_RST && cfg.ldma_pri == LDMA_PRI_RST;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset priorities");
endmodule

// ### l2a_req_model.sv
// behavioural requestors facing the arbiter: coherence engines, cpu and both dma sources
// assumes a one-cycle grant pulse per command, seen on the rising edge
`timescale 1ns/1ps
module l2a_req_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [4:0][7:0] n_in,
  input wire logic [3:0] grant,
  input wire logic grant_local_dma,
  output logic glb_coh_req,
  output logic cpu_req,
  output logic slave_dma_req,
  output logic slave_dma_last,
  output logic local_dma_req,
  output logic usr_coh_req,
  output logic idle
);
  logic [4:0][7:0] cnt;
  logic [4:0] hit;
  // a command stays posted until its grant, so a busy arbiter keeps seeing it
  assign hit = {grant[3], grant[2] & grant_local_dma, grant[2] & ~grant_local_dma, grant[1:0]};
  assign glb_coh_req = cnt[0] != 8'h0;
  assign cpu_req = cnt[1] != 8'h0;
  assign slave_dma_req = cnt[2] != 8'h0;
  assign local_dma_req = cnt[3] != 8'h0;
  assign usr_coh_req = cnt[4] != 8'h0;
  // last command with nothing behind it
  assign slave_dma_last = cnt[2] == 8'h01;
  assign idle = cnt == 40'h0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= n_in;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (hit[i] && cnt[i] != 8'h0) begin
          cnt[i] <= cnt[i] - 8'h01;
        end
      end
    end
  end
endmodule

// ### tb_l2a_arbiter.sv
// self-checking bench of the l2 requestor arbiter: first-grant table, then hand tests
// assumes l2a_req_model as the requestors and a 100 MHz clock
`timescale 1ns/1ps
module tb_l2a_arbiter;
  import l2a_pkg::*;
  typedef struct packed {
    logic [4:0][7:0] n;
    logic [2:0] cpu_pri;
    logic [2:0] ld_pri;
    logic [2:0] sd_pri;
    logic [4:0] exp_gnt;
  } l2a_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic glb_coh_req, cpu_req, slave_dma_req, slave_dma_last, local_dma_req, usr_coh_req, idle;
  logic [PW-1:0] slave_dma_pri = '0;
  logic slave_dma_xfer_start = 1'b0;
  logic [PW-1:0] slave_dma_xfer_pri = '0;
  logic [NRQ-1:0] grant;
  logic grant_local_dma;
  logic load = 1'b0;
  logic [4:0][7:0] n_in = '0;
  logic [4:0] seq [$];
  logic [31:0] rd;
  l2a_row_t rows [9];
  int n_fail = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  l2a_arbiter u_l2a_arbiter (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .glb_coh_req(glb_coh_req), .cpu_req(cpu_req), .slave_dma_req(slave_dma_req),
    .slave_dma_pri(slave_dma_pri), .slave_dma_last(slave_dma_last),
    .slave_dma_xfer_start(slave_dma_xfer_start), .slave_dma_xfer_pri(slave_dma_xfer_pri),
    .local_dma_req(local_dma_req), .usr_coh_req(usr_coh_req), .grant(grant),
    .grant_local_dma(grant_local_dma));
  l2a_req_model u_l2a_req_model (.clk(clk), .sys_rst(sys_rst), .load(load), .n_in(n_in),
    .grant(grant), .grant_local_dma(grant_local_dma), .glb_coh_req(glb_coh_req),
    .cpu_req(cpu_req), .slave_dma_req(slave_dma_req), .slave_dma_last(slave_dma_last),
    .local_dma_req(local_dma_req), .usr_coh_req(usr_coh_req), .idle(idle));
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_gnt(input string nm, input logic [4:0] e, input logic [4:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon cycle; waits for the slave with no assumed latency
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      $display("unexpected bus stall");
    end
  endtask
  task automatic load_set(input logic [4:0][7:0] n);
    @(posedge clk);
    load <= 1'b1;
    n_in <= n;
    @(posedge clk);
    load <= 1'b0;
  endtask
  task automatic collect(input int n);
    int k = 0;
    seq = {};
    while (seq.size() < n && k < 300) begin
      @(posedge clk);
      #1;
      if (grant !== 4'h0) begin
        seq.push_back({grant_local_dma, grant});
      end
      k++;
    end
    if (seq.size() < n) begin
      n_fail++;
      $display("unexpected grant count expected %0d seen %0d", n, seq.size());
    end
  endtask
  task automatic drain();
    int k = 0;
    while (idle !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    if (k >= 500) begin
      n_fail++;
      $display("unexpected drain timeout");
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic done(input string nm);
    $display("test %s ended, %0d mismatches so far", nm, n_fail);
  endtask
  initial begin
    #100000;
    n_fail++;
    $display("unexpected watchdog expiry");
    final_report();
  end
  initial begin
    // n holds command counts {user, local, slave, cpu, global}
    rows[0] = '{40'h0100020101, 3'h1, 3'h0, 3'h1, 5'h01};
    rows[1] = '{40'h0000020100, 3'h2, 3'h0, 3'h1, 5'h04};
    rows[2] = '{40'h0000020100, 3'h0, 3'h0, 3'h1, 5'h02};
    rows[3] = '{40'h0100000000, 3'h1, 3'h0, 3'h0, 5'h08};
    rows[4] = '{40'h0100000100, 3'h1, 3'h0, 3'h0, 5'h02};
    rows[5] = '{40'h0000010100, 3'h6, 3'h0, 3'h0, 5'h02};
    rows[6] = '{40'h0001000000, 3'h1, 3'h0, 3'h0, 5'h14};
    rows[7] = '{40'h0001020000, 3'h1, 3'h0, 3'h2, 5'h14};
    rows[8] = '{40'h0001020000, 3'h1, 3'h3, 3'h2, 5'h04};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk_gnt("grant after reset", 5'h00, {grant_local_dma, grant});
    bus(1'b0, OFS_CPU_PRI, 32'h0);
    chk_reg("cpu priority reset", 32'h1, rd);
    bus(1'b0, OFS_LDMA, 32'h0);
    chk_reg("local priority reset", 32'h0, rd);
    bus(1'b0, OFS_THR, 32'h0);
    chk_reg("threshold reset", 32'h00101010, rd);
    bus(1'b1, 4'h1, 32'hffffffff);
    bus(1'b0, 4'h1, 32'h0);
    chk_reg("unmapped read", 32'h0, rd);
    bus(1'b0, OFS_CPU_PRI, 32'h0);
    chk_reg("cpu priority kept", 32'h1, rd);
    slave_dma_pri <= 3'h5;
    bus(1'b0, OFS_STAT, 32'h0);
    chk_reg("status idle", 32'h50, rd);
    done("reset");
    foreach (rows[i]) begin
      // cpu level never 7 here
      bus(1'b1, OFS_CPU_PRI, {29'h0, rows[i].cpu_pri});
      bus(1'b1, OFS_LDMA, {29'h0, rows[i].ld_pri});
      slave_dma_pri <= rows[i].sd_pri;
      load_set(rows[i].n);
      collect(1);
      chk_gnt("first grant", rows[i].exp_gnt, seq[0]);
      drain();
    end
    done("table");
    // global takes every other slot, so the cpu is eligible at both ties
    slave_dma_pri <= 3'h1;
    load_set(40'h0000040408);
    collect(4);
    for (int i = 0; i < 4; i++) begin
      chk_gnt("tie order", (i % 2 == 0) ? 5'h01 : (i == 1 ? 5'h02 : 5'h04), seq[i]);
    end
    drain();
    done("tie");
    slave_dma_pri <= 3'h0;
    load_set(40'h0000010808);
    slave_dma_xfer_start <= 1'b1;
    slave_dma_xfer_pri <= 3'h0;
    @(posedge clk);
    slave_dma_xfer_start <= 1'b0;
    collect(1);
    chk_gnt("inherited grant", 5'h04, seq[0]);
    drain();
    done("inherit");
    slave_dma_pri <= 3'h1;
    bus(1'b1, OFS_THR, 32'h00021010);
    load_set(40'h0200141400);
    collect(7);
    chk_gnt("starved user", 5'h08, seq[2]);
    chk_gnt("user after clear", 5'h00, {4'h0, seq[4][3]});
    chk_gnt("user again", 5'h08, seq[6]);
    drain();
    done("starve");
    final_report();
  end
endmodule
